// ===== rtl/fus_ctrl.v
// User signature sequencer: commands, address remap, page program, erase, verify
//
// Functional notes
// - A separate 512-byte signature store that software can read, program, erase.
// - Start-read code in the command field begins read mode; argument ignored.
// - Start-read drops the ready flag; software waits for that before reading.
// - In read mode the first 512 window bytes return signature data instead.
// - Stop-read code ends read mode, argument ignored, main mapping restored.
// - Stop-read completion raises ready and, if enabled, the interrupt line.
// - A wrong key in a command write sets the command error flag.
// - Write-signature code programs the buffered page; argument ignored.
// - End of program or erase raises ready and, if enabled, the interrupt.
// - Program is followed by a verify; a mismatch sets the flash error flag.
// - Erase-signature code erases the signature area; argument ignored.
// - Erase is followed by an erase verify; failure sets the flash error flag.
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "fus_map.vh"
module fus_ctrl #(
    parameter ADDR_W      = 20,
    parameter TW          = 16,
    parameter PROG_CYCLES = 16'd500,
    parameter ERASE_CYCLES = 16'd1000
) (
    input  wire                  clk,
    input  wire                  rst_b,
    input  wire [`FUS_REG_AW-1:0] reg_addr,
    input  wire [31:0]           reg_wdata,
    input  wire                  reg_wr,
    input  wire                  reg_rd,
    output reg  [31:0]           reg_rdata_q,
    input  wire [ADDR_W-1:0]     win_addr,
    input  wire                  win_rd,
    input  wire                  win_wr,
    input  wire [31:0]           win_wdata,
    input  wire [31:0]           main_rdata,
    input  wire                  array_wr_inhibit,
    output reg  [31:0]           win_rdata_q,
    output reg                   win_rvalid_q,
    output reg                   ready_flag_q,
    output reg                   irq_q
);
    localparam S_IDLE  = 6'h01;
    localparam S_RMODE = 6'h02;
    localparam S_PROG  = 6'h04;
    localparam S_ERASE = 6'h08;
    localparam S_WAIT  = 6'h10;
    localparam S_VER   = 6'h20;
    localparam [`FUS_SIG_AW-1:0] IDX_LAST = {`FUS_SIG_AW{1'b1}};
    localparam [`FUS_SIG_AW-1:0] IDX_ONE  = {{(`FUS_SIG_AW-1){1'b0}}, 1'b1};

    reg  [5:0]               st_q;
    reg  [5:0]               st_d;
    reg  [`FUS_SIG_AW-1:0]   idx_q;
    reg  [`FUS_SIG_AW-1:0]   idx_d;
    reg                      ph_q;
    reg                      ph_d;
    reg                      erase_op_q;
    reg                      erase_op_d;
    reg                      vfail_q;
    reg                      vfail_d;
    reg                      ready_d;
    reg                      tmr_start;
    reg                      ev_done;
    reg                      ev_cerr;
    reg                      ev_ferr;
    reg                      cmd_err_q;
    reg                      flash_err_q;
    reg  [`FUS_EV_W-1:0]     istat_q;
    reg  [`FUS_EV_W-1:0]     ien_q;
    reg                      sel_sig_q;
    reg                      rd_pend_q;
    reg  [31:0]              main_q;
    reg  [31:0]              rdata_d;

    wire                     tmr_done;
    wire [31:0]              sig_rdata;
    wire [31:0]              pb_rdata;
    wire [`FUS_SIG_AW-1:0]   win_idx;
    wire [`FUS_SIG_AW-1:0]   sig_raddr;
    wire                     seq_busy;
    wire                     cmd_wr;
    wire                     key_ok;
    wire [7:0]               code;
    wire                     sig_we;
    wire [31:0]              sig_wdata;
    wire                     stat_rd;
    wire                     iclr_wr;
    wire [`FUS_EV_W-1:0]     ev_vec;
    wire [31:0]              exp_word;
    wire                     win_low;

    assign win_idx   = win_addr[`FUS_WORD_LSB+`FUS_SIG_AW-1:`FUS_WORD_LSB];
    assign seq_busy  = (st_q == S_PROG) || (st_q == S_ERASE) || (st_q == S_VER);
    // Sequencer owns the store while busy; software may not read it then anyway
    assign sig_raddr = seq_busy ? idx_q : win_idx;
    assign cmd_wr    = reg_wr && (reg_addr == `FUS_OFF_CMD);
    assign key_ok    = reg_wdata[`FUS_KEY_HI:`FUS_KEY_LO] == `FUS_CMD_KEY;
    assign code      = reg_wdata[`FUS_CODE_HI:`FUS_CODE_LO];
    assign stat_rd   = reg_rd && (reg_addr == `FUS_OFF_STAT);
    assign iclr_wr   = reg_wr && (reg_addr == `FUS_OFF_ICLR);
    // Inhibited array writes leave old contents, so verify reports them
    assign sig_we    = (((st_q == S_PROG) && ph_q) || (st_q == S_ERASE)) && !array_wr_inhibit;
    assign sig_wdata = erase_op_q ? `FUS_ERASED_WORD : pb_rdata;
    assign exp_word  = erase_op_q ? `FUS_ERASED_WORD : pb_rdata;
    // Read mode remaps only the low window; upper address bits must all be clear
    assign win_low   = ~|win_addr[ADDR_W-1:`FUS_WORD_LSB+`FUS_SIG_AW];

    // Page buffer, filled by any window write
    fus_mem #(
        .DW      (32),
        .AW      (`FUS_SIG_AW)
    ) u_page_buf (
        .clk     (clk),
        .rst_b   (rst_b),
        .we      (win_wr),
        .waddr   (win_idx),
        .wdata   (win_wdata),
        .raddr   (idx_q),
        .rdata_q (pb_rdata)
    );

    // Signature store, physically apart from the main array
    fus_mem #(
        .DW      (32),
        .AW      (`FUS_SIG_AW)
    ) u_sig_store (
        .clk     (clk),
        .rst_b   (rst_b),
        .we      (sig_we),
        .waddr   (idx_q),
        .wdata   (sig_wdata),
        .raddr   (sig_raddr),
        .rdata_q (sig_rdata)
    );

    // One timer serves both operations; length picked by the accepted command
    fus_op_timer #(
        .CW      (TW)
    ) u_timer (
        .clk     (clk),
        .rst_b   (rst_b),
        .start   (tmr_start),
        .count   (erase_op_q ? ERASE_CYCLES : PROG_CYCLES),
        .done_q  (tmr_done)
    );

    always @* begin
        st_d       = st_q;
        idx_d      = idx_q;
        ph_d       = ph_q;
        erase_op_d = erase_op_q;
        vfail_d    = vfail_q;
        ready_d    = ready_flag_q;
        tmr_start  = 1'b0;
        ev_done    = 1'b0;
        ev_cerr    = 1'b0;
        ev_ferr    = 1'b0;
        case (st_q)
            S_PROG: begin
                ph_d = !ph_q;
                if (ph_q) begin
                    idx_d = idx_q + IDX_ONE;
                    if (idx_q == IDX_LAST) begin
                        st_d      = S_WAIT;
                        tmr_start = 1'b1;
                    end
                end
            end
            S_ERASE: begin
                idx_d = idx_q + IDX_ONE;
                if (idx_q == IDX_LAST) begin
                    st_d      = S_WAIT;
                    tmr_start = 1'b1;
                end
            end
            S_WAIT: begin
                // Pulse time passes with the store left alone
                if (tmr_done) begin
                    st_d  = S_VER;
                    idx_d = {`FUS_SIG_AW{1'b0}};
                    ph_d  = 1'b0;
                end
            end
            S_VER: begin
                ph_d = !ph_q;
                if (ph_q) begin
                    idx_d = idx_q + IDX_ONE;
                    if (sig_rdata != exp_word) begin
                        vfail_d = 1'b1;
                    end
                    if (idx_q == IDX_LAST) begin
                        st_d    = S_IDLE;
                        ready_d = 1'b1;
                        ev_done = 1'b1;
                        ev_ferr = vfail_q || (sig_rdata != exp_word);
                    end
                end
            end
            S_IDLE, S_RMODE: begin
            end
            default: begin
                st_d    = S_IDLE;
                ready_d = 1'b1;
            end
        endcase
        // A refused command only raises the command error; state is kept
        if (cmd_wr) begin
            if (!key_ok) begin
                ev_cerr = 1'b1;
            end else begin
                case (code)
                    `FUS_CMD_START_RD: begin
                        if (st_q == S_IDLE) begin
                            st_d    = S_RMODE;
                            ready_d = 1'b0;
                        end else begin
                            ev_cerr = 1'b1;
                        end
                    end
                    `FUS_CMD_STOP_RD, `FUS_CMD_STOP_ALT: begin
                        if (st_q == S_RMODE || st_q == S_IDLE) begin
                            st_d    = S_IDLE;
                            ready_d = 1'b1;
                            ev_done = 1'b1;
                        end else begin
                            ev_cerr = 1'b1;
                        end
                    end
                    `FUS_CMD_WRITE, `FUS_CMD_ERASE: begin
                        if (st_q == S_IDLE) begin
                            st_d       = (code == `FUS_CMD_ERASE) ? S_ERASE : S_PROG;
                            erase_op_d = (code == `FUS_CMD_ERASE);
                            idx_d      = {`FUS_SIG_AW{1'b0}};
                            ph_d       = 1'b0;
                            vfail_d    = 1'b0;
                            ready_d    = 1'b0;
                        end else begin
                            ev_cerr = 1'b1;
                        end
                    end
                    default: begin
                        ev_cerr = 1'b1;
                    end
                endcase
            end
        end
    end

    // Ready comes up high so software may issue a command straight after reset
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q         <= S_IDLE;
            idx_q        <= {`FUS_SIG_AW{1'b0}};
            ph_q         <= 1'b0;
            erase_op_q   <= 1'b0;
            vfail_q      <= 1'b0;
            ready_flag_q <= 1'b1;
        end else begin
            st_q         <= st_d;
            idx_q        <= idx_d;
            ph_q         <= ph_d;
            erase_op_q   <= erase_op_d;
            vfail_q      <= vfail_d;
            ready_flag_q <= ready_d;
        end
    end

    assign ev_vec = {ev_ferr, ev_cerr, ev_done};

    // Status errors clear on a status read; a new error in that cycle survives
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_err_q   <= 1'b0;
            flash_err_q <= 1'b0;
            istat_q     <= {`FUS_EV_W{1'b0}};
            ien_q       <= `FUS_MODE_RST;
            irq_q       <= 1'b0;
        end else begin
            cmd_err_q   <= ev_cerr || (cmd_err_q && !stat_rd);
            flash_err_q <= ev_ferr || (flash_err_q && !stat_rd);
            istat_q     <= ev_vec | (istat_q & ~(iclr_wr ? reg_wdata[`FUS_EV_W-1:0]
                                                         : {`FUS_EV_W{1'b0}}));
            if (reg_wr && reg_addr == `FUS_OFF_MODE) begin
                ien_q <= reg_wdata[`FUS_EV_W-1:0];
            end
            irq_q       <= |(istat_q & ien_q);
        end
    end

    // Unmapped and write-only offsets read as zero
    always @* begin
        rdata_d = 32'h0000_0000;
        case (reg_addr)
            `FUS_OFF_MODE: begin
                rdata_d[`FUS_EV_W-1:0] = ien_q;
            end
            `FUS_OFF_STAT: begin
                rdata_d[`FUS_ST_READY]  = ready_flag_q;
                rdata_d[`FUS_ST_CMDERR] = cmd_err_q;
                rdata_d[`FUS_ST_FLERR]  = flash_err_q;
                rdata_d[`FUS_ST_RMODE]  = (st_q == S_RMODE);
            end
            `FUS_OFF_ISTAT: begin
                rdata_d[`FUS_EV_W-1:0] = istat_q;
            end
            default: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    // Read data stand for one cycle only, zero otherwise
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata_q <= rdata_d;
        end else begin
            reg_rdata_q <= 32'h0000_0000;
        end
    end

    // Window read: store has one cycle of latency, so main data is held to match
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_sig_q    <= 1'b0;
            rd_pend_q    <= 1'b0;
            main_q       <= 32'h0000_0000;
            win_rdata_q  <= 32'h0000_0000;
            win_rvalid_q <= 1'b0;
        end else begin
            rd_pend_q    <= win_rd;
            sel_sig_q    <= (st_q == S_RMODE) && win_low;
            main_q       <= main_rdata;
            win_rvalid_q <= rd_pend_q;
            if (rd_pend_q) begin
                win_rdata_q <= sel_sig_q ? sig_rdata : main_q;
            end
        end
    end
endmodule

// ===== rtl/fus_map.vh
// Register map, field layout and command codes of the user signature sequencer
`ifndef FUS_MAP_VH
`define FUS_MAP_VH

`define FUS_REG_AW        8
`define FUS_OFF_MODE      8'h00
`define FUS_OFF_CMD       8'h04
`define FUS_OFF_STAT      8'h08
`define FUS_OFF_ISTAT     8'h0c
`define FUS_OFF_ICLR      8'h10

`define FUS_CODE_HI       7
`define FUS_CODE_LO       0
`define FUS_ARG_HI        23
`define FUS_ARG_LO        8
`define FUS_KEY_HI        31
`define FUS_KEY_LO        24
// Key value is arbitrary
`define FUS_CMD_KEY       8'ha5

`define FUS_CMD_START_RD  8'h01
`define FUS_CMD_STOP_RD   8'h02
`define FUS_CMD_STOP_ALT  8'h05
`define FUS_CMD_WRITE     8'h03
`define FUS_CMD_ERASE     8'h04

`define FUS_ST_READY      0
`define FUS_ST_CMDERR     1
`define FUS_ST_FLERR      2
`define FUS_ST_RMODE      3
`define FUS_ST_W          4

`define FUS_EV_DONE       0
`define FUS_EV_CMDERR     1
`define FUS_EV_FLERR      2
`define FUS_EV_W          3
`define FUS_MODE_RST      3'h0

`define FUS_SIG_BYTES     512
`define FUS_SIG_AW        7
`define FUS_WORD_LSB      2
`define FUS_ERASED_WORD   32'hffffffff

`endif

// ===== rtl/fus_mem.v
// Simple dual-port word memory with registered read data
`timescale 1ns/10ps
module fus_mem #(
    parameter DW = 32,
    parameter AW = 7
) (
    input  wire          clk,
    input  wire          rst_b,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    input  wire [AW-1:0] raddr,
    output reg  [DW-1:0] rdata_q
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= {DW{1'b0}};
        end else begin
            rdata_q <= mem[raddr];
        end
    end
endmodule

// ===== rtl/fus_op_timer.v
// Down counter that times a program or erase pulse
`timescale 1ns/10ps
module fus_op_timer #(
    parameter CW = 16
) (
    input  wire          clk,
    input  wire          rst_b,
    input  wire          start,
    input  wire [CW-1:0] count,
    output reg           done_q
);
    reg [CW-1:0] cnt_q;
    reg          run_q;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q  <= {CW{1'b0}};
            run_q  <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start) begin
                cnt_q <= count;
                run_q <= 1'b1;
            end else if (run_q) begin
                if (cnt_q <= {{(CW-1){1'b0}}, 1'b1}) begin
                    run_q  <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// ===== tb/fus_ctrl_props.sv
// Port-level assertions for the user signature sequencer
`timescale 1ns/10ps
`include "fus_map.vh"
module fus_ctrl_props #(
    parameter ADDR_W = 20
) (
    input wire logic                    clk,
    input wire logic                    rst_b,
    input wire logic [`FUS_REG_AW-1:0]  reg_addr,
    input wire logic [31:0]             reg_wdata,
    input wire logic                    reg_wr,
    input wire logic                    reg_rd,
    input wire logic [31:0]             reg_rdata_q,
    input wire logic [ADDR_W-1:0]       win_addr,
    input wire logic                    win_rd,
    input wire logic                    win_wr,
    input wire logic [31:0]             win_wdata,
    input wire logic [31:0]             main_rdata,
    input wire logic                    array_wr_inhibit,
    input wire logic [31:0]             win_rdata_q,
    input wire logic                    win_rvalid_q,
    input wire logic                    ready_flag_q,
    input wire logic                    irq_q
);
    logic rmode_q;
    logic rmode_d;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Read mode rebuilt from commands; start is only taken while ready
    always @* begin
        rmode_d = rmode_q;
        if (reg_wr && reg_addr == `FUS_OFF_CMD && reg_wdata[31:24] == `FUS_CMD_KEY) begin
            if (reg_wdata[7:0] == `FUS_CMD_START_RD && ready_flag_q)
                rmode_d = 1'b1;
            if (reg_wdata[7:0] == `FUS_CMD_STOP_RD || reg_wdata[7:0] == `FUS_CMD_STOP_ALT)
                rmode_d = 1'b0;
        end
    end
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            rmode_q <= 1'b0;
        else
            rmode_q <= rmode_d;
    end

    sequence s_cmd(logic [7:0] code);
        reg_wr && reg_addr == `FUS_OFF_CMD && reg_wdata[31:24] == `FUS_CMD_KEY
            && reg_wdata[7:0] == code;
    endsequence
    sequence s_badkey;
        reg_wr && reg_addr == `FUS_OFF_CMD && reg_wdata[31:24] != `FUS_CMD_KEY;
    endsequence
    sequence s_stat_rd;
        reg_rd && reg_addr == `FUS_OFF_STAT;
    endsequence
    sequence s_op;
        (s_cmd(`FUS_CMD_WRITE) or s_cmd(`FUS_CMD_ERASE)) ##0 ready_flag_q;
    endsequence

    property p_rdata_idle;
        !reg_rd |=> reg_rdata_q == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
    property p_start_drop;
        s_cmd(`FUS_CMD_START_RD) |=> !ready_flag_q;
    endproperty
    a_start_drop: assert property (p_start_drop) else $error("ready kept");
    property p_stop_raise;
        (s_cmd(`FUS_CMD_STOP_RD) or s_cmd(`FUS_CMD_STOP_ALT)) ##0 (ready_flag_q || rmode_q)
            |=> ready_flag_q;
    endproperty
    a_stop_raise: assert property (p_stop_raise) else $error("stop left ready low");
    property p_win_main;
        win_rd && (!rmode_q || win_addr >= 512)
            |-> ##2 win_rvalid_q && win_rdata_q == $past(main_rdata, 2);
    endproperty
    a_win_main: assert property (p_win_main) else $error("main data lost");
    property p_win_quiet;
        !win_rd |-> ##2 !win_rvalid_q;
    endproperty
    a_win_quiet: assert property (p_win_quiet) else $error("stray window valid");
    property p_op_busy;
        s_op |=> !ready_flag_q [*8];
    endproperty
    a_op_busy: assert property (p_op_busy) else $error("ready high while busy");
    property p_op_done;
        s_op |-> ##[1:1000] ready_flag_q;
    endproperty
    a_op_done: assert property (p_op_done) else $error("operation never ended");
    property p_badkey;
        s_badkey ##2 s_stat_rd |=> reg_rdata_q[`FUS_ST_CMDERR];
    endproperty
    a_badkey: assert property (p_badkey) else $error("bad key not flagged");
    property p_irq_off;
        reg_wr && reg_addr == `FUS_OFF_MODE && reg_wdata[2:0] == 3'h0 |=> ##1 !irq_q;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("masked interrupt high");
endmodule

bind fus_ctrl fus_ctrl_props #(.ADDR_W(ADDR_W)) u_fus_ctrl_props (
    .clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .win_addr,
    .win_rd, .win_wr, .win_wdata, .main_rdata, .array_wr_inhibit, .win_rdata_q,
    .win_rvalid_q, .ready_flag_q, .irq_q
);

// ===== tb/fus_ctrl_test.sv
// Self-checking bench for the user signature sequencer
`timescale 1ns/10ps
`include "fus_map.vh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fails++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module fus_ctrl_test;
    logic        clk;
    logic        rst_b;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    wire  [31:0] reg_rdata_q;
    logic [19:0] win_addr;
    logic        win_rd;
    logic        win_wr;
    logic [31:0] win_wdata;
    logic [31:0] main_rdata;
    logic        array_wr_inhibit;
    wire  [31:0] win_rdata_q;
    wire         win_rvalid_q;
    wire         ready_flag_q;
    wire         irq_q;
    logic [31:0] d;
    int          fails;
    int          n_tests;
    int          i;
    int          k;

    // Short pulse counts keep program and erase to a few hundred cycles
    fus_ctrl #(.PROG_CYCLES(16'd4), .ERASE_CYCLES(16'd4)) u_fus_ctrl (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .win_addr(win_addr),
        .win_rd(win_rd), .win_wr(win_wr), .win_wdata(win_wdata), .main_rdata(main_rdata),
        .array_wr_inhibit(array_wr_inhibit), .win_rdata_q(win_rdata_q),
        .win_rvalid_q(win_rvalid_q), .ready_flag_q(ready_flag_q), .irq_q(irq_q));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic [31:0] pat(input int n);
        return 32'hc0de0000 + 32'(n);
    endfunction
    function automatic [31:0] mainv(input [19:0] a);
        return {12'h0, a} ^ 32'h55555555;
    endfunction

    task automatic wr(input [7:0] a, input [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input [7:0] a, output [31:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata_q;
    endtask
    task automatic cmd(input [7:0] code, input [15:0] arg);
        wr(`FUS_OFF_CMD, {`FUS_CMD_KEY, arg, code});
        #1;
    endtask
    task automatic wait_rdy();
        for (int n = 0; n < 2000 && ready_flag_q !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        `CHK(ready_flag_q, 1'b1)
    endtask
    // Any page address will do; only the word index lands in the buffer
    task automatic fill();
        for (int n = 0; n < 128; n++) begin
            @(posedge clk);
            win_wr <= 1'b1;
            win_addr <= 20'h04000 + 20'(n * 4);
            win_wdata <= pat(n);
        end
        @(posedge clk);
        win_wr <= 1'b0;
    endtask
    task automatic wread(input [19:0] a, output [31:0] v);
        @(posedge clk);
        win_rd <= 1'b1;
        win_addr <= a;
        main_rdata <= mainv(a);
        @(posedge clk);
        win_rd <= 1'b0;
        for (int n = 0; n < 4 && win_rvalid_q !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        `CHK(win_rvalid_q, 1'b1)
        v = win_rdata_q;
    endtask
    task automatic close_out();
        $display("fails %0d n_tests %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #80000;
        fails++;
        close_out();
    end

    initial begin
        {rst_b, reg_addr, reg_wdata, reg_wr, reg_rd, win_addr, win_rd, win_wr} = '0;
        {win_wdata, main_rdata, array_wr_inhibit, fails, n_tests} = '0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        #1 `CHK({ready_flag_q, irq_q, reg_rdata_q}, {2'b10, 32'h0})
        rd(`FUS_OFF_MODE, d); `CHK(d[2:0], `FUS_MODE_RST)
        wr(`FUS_OFF_MODE, 32'h7);
        rd(`FUS_OFF_MODE, d); `CHK(d[2:0], 3'h7)
        rd(8'h14, d); `CHK(d, 32'h0)
        wr(`FUS_OFF_CMD, {8'h5b, 16'h0, `FUS_CMD_START_RD});
        rd(`FUS_OFF_STAT, d); `CHK(d[3:0], 4'b0011)
        rd(`FUS_OFF_STAT, d); `CHK(d[1], 1'b0)
        rd(`FUS_OFF_ISTAT, d); `CHK({d[2:0], irq_q}, 4'b0101)
        wr(`FUS_OFF_ICLR, 32'h7);
        repeat (2) @(posedge clk);
        #1 `CHK(irq_q, 1'b0)
        fill();
        cmd(`FUS_CMD_WRITE, 16'hbeef); `CHK(ready_flag_q, 1'b0)
        wait_rdy();
        rd(`FUS_OFF_STAT, d); `CHK(d[3:0], 4'b0001)
        rd(`FUS_OFF_ISTAT, d); `CHK({d[2:0], irq_q}, 4'b0011)
        wr(`FUS_OFF_ICLR, 32'h7);
        cmd(`FUS_CMD_START_RD, 16'hffff); `CHK(ready_flag_q, 1'b0)
        cmd(`FUS_CMD_WRITE, 16'h0);
        rd(`FUS_OFF_STAT, d); `CHK(d[3:0], 4'b1010)
        for (i = 0; i < 128; i++) begin
            wread(20'(i * 4), d); `CHK(d, pat(i))
        end
        wread(20'h00200, d); `CHK(d, mainv(20'h00200))
        for (k = 0; k < 2; k++) begin
            if (k == 1)
                cmd(`FUS_CMD_START_RD, 16'h0);
            wr(`FUS_OFF_ICLR, 32'h7);
            cmd(k == 0 ? `FUS_CMD_STOP_RD : `FUS_CMD_STOP_ALT, 16'h1234);
            `CHK(ready_flag_q, 1'b1)
            repeat (2) @(posedge clk);
            #1 `CHK(irq_q, 1'b1)
            wread(20'h0, d); `CHK(d, mainv(20'h0))
        end
        rd(`FUS_OFF_STAT, d);
        @(posedge clk);
        array_wr_inhibit <= 1'b1;
        wr(`FUS_OFF_MODE, 32'h0);
        wr(`FUS_OFF_ICLR, 32'h7);
        cmd(`FUS_CMD_ERASE, 16'h00aa); `CHK(ready_flag_q, 1'b0)
        wait_rdy();
        rd(`FUS_OFF_STAT, d); `CHK(d[2:0], 3'b101)
        rd(`FUS_OFF_ISTAT, d); `CHK({d[2:0], irq_q}, 4'b1010)
        @(posedge clk);
        array_wr_inhibit <= 1'b0;
        wr(`FUS_OFF_MODE, 32'h7);
        repeat (2) @(posedge clk);
        #1 `CHK(irq_q, 1'b1)
        wr(`FUS_OFF_ICLR, 32'h7);
        cmd(`FUS_CMD_ERASE, 16'h0);
        wait_rdy();
        rd(`FUS_OFF_STAT, d); `CHK(d[2:0], 3'b001)
        cmd(`FUS_CMD_START_RD, 16'h0);
        for (i = 0; i < 128; i += 37) begin
            wread(20'(i * 4), d); `CHK(d, `FUS_ERASED_WORD)
        end
        cmd(`FUS_CMD_STOP_RD, 16'h0);
        fill();
        @(posedge clk);
        array_wr_inhibit <= 1'b1;
        cmd(`FUS_CMD_WRITE, 16'h0);
        wait_rdy();
        rd(`FUS_OFF_STAT, d); `CHK(d[2:0], 3'b101)
        close_out();
    end
endmodule
